// ==== rtl/pmc_pkg.sv ====
/*
  Shared constants for the multi-mode pulse counter: register map, control
  field layout, mode and operation codes, unit states and period limits.
  Assumes a 10 MHz register clock that also serves as the data clock.
*/
package pmc_pkg;

  localparam real CLK_PERIOD_NS = 100.0;
  localparam real PERIOD_MIN_NS = 93.3;
  localparam real PERIOD_MAX_NS = 1000000000.0;
  localparam int  PERIOD_MIN_CYC = (int'($ceil(PERIOD_MIN_NS / CLK_PERIOD_NS)) < 1) ? 1 :
                                   int'($ceil(PERIOD_MIN_NS / CLK_PERIOD_NS));
  localparam int  PERIOD_MAX_CYC = int'($floor(PERIOD_MAX_NS / CLK_PERIOD_NS));

  localparam int  NUM_SRC   = 36;
  localparam int  NUM_IN    = 40;
  localparam int  GATE_BASE = 36;

  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_PERIOD = 2'h1;
  localparam logic [1:0] REG_VALUE  = 2'h2;
  localparam logic [1:0] REG_STAMP  = 2'h3;

  localparam int F_EN    = 0;
  localparam int F_MODE  = 1;
  localparam int F_RISE  = 3;
  localparam int F_FALL  = 4;
  localparam int F_SRC   = 5;
  localparam int F_GATE  = 11;
  localparam int F_OP    = 14;
  localparam int F_INTEG = 16;
  localparam int F_NEW   = 31;

  localparam logic [31:0] CTRL_WMASK = 32'h0001FFFF;
  localparam logic [31:0] CTRL_RST   = 32'h00000000;

  localparam logic [1:0] MODE_FREE  = 2'h0;
  localparam logic [1:0] MODE_GFREE = 2'h1;
  localparam logic [1:0] MODE_GATED = 2'h2;
  localparam logic [1:0] MODE_TAG   = 2'h3;

  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_ADD  = 2'h1;
  localparam logic [1:0] OP_SUB  = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b100
  } pmc_state_e;

endpackage : pmc_pkg

// ==== rtl/pmc_reg_if.sv ====
/*
  Carrier between the APB front end and the register file of the counter.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface pmc_reg_if;
  logic        wr;
  logic        rd;
  logic [1:0]  unit;
  logic [1:0]  regsel;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport front (output wr, output rd, output unit, output regsel, output wdata, input rdata);
  modport regs  (input wr, input rd, input unit, input regsel, input wdata, output rdata);
endinterface : pmc_reg_if
`default_nettype wire

// ==== rtl/pmc_apb_slave.sv ====
/*
  APB slave front end: decodes the address, answers one cycle into the access
  phase and hands one-cycle write and read strobes to the register file.
  Assumes a well-behaved APB master on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_apb_slave #(
  parameter int NUM_UNITS = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  pmc_reg_if.front         rif
);
  logic        hit;
  logic        done;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  always_comb begin
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr[11:6] != 6'h00) begin
      hit = 1'b0;
    end else if (int'(paddr[5:4]) >= NUM_UNITS) begin
      hit = 1'b0;
    end else begin
      hit = 1'b1;
    end
  end

  assign done       = psel & penable & pready_q;
  assign rif.wr     = done & pwrite & hit;
  assign rif.rd     = done & ~pwrite & hit;
  assign rif.unit   = paddr[5:4];
  assign rif.regsel = paddr[3:2];
  assign rif.wdata  = pwdata;

  // Answer is computed one cycle into the access phase so read data is stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite & hit) ? rif.rdata : 32'h00000000;
      pslverr_q <= psel & penable & ~pready_q & ~hit;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
endmodule : pmc_apb_slave
`default_nettype wire

// ==== rtl/pmc_top.sv ====
/*
  Multi-mode pulse counter: input synchronisers, per-unit counting engines,
  partner arithmetic, integration and the register file behind APB.
  Assumes source, gate and trigger inputs may be asynchronous and that the
  register clock is also the data clock for counting and timestamps.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Free running: clear per period, output total
// (R2) Gated free running: gate low clears count, timer
// (R3) Gated free running: result only after full period
// (R4) Gated: count only between gate edges
// (R5) Gated: result at gate falling edge
// (R6) Tagging: report each pulse with timestamp
// (R7) Tagging: period is minimum report hold-off
// (R8) Tagging: pulses in window give one report
// (R9) Period limited to 93.3 ns .. 1 s
// (R10) Source from four triggers or 32 lines
// (R11) Rising selection counts low-to-high crossings
// (R12) Falling selection counts high-to-low; both count both
// (R13) Gate from four triggers or sequencer triggers
// (R14) Operation: none, add or subtract partner
// (R15) Partners are units one/two, three/four
// (R16) Integration sums successive results
// (R17) Disabled unit produces no results
// (R18) Latest result readable per unit
// (R19) Timestamps counted in data clock cycles
// (R20) Count at up to maximum rate
// (R21) Synchronise source and gate inputs first
module pmc_top #(
  parameter int NUM_UNITS      = 4,
  parameter int CNT_W          = 32,
  parameter int PER_W          = 24,
  parameter int PERIOD_MAX_CYC = pmc_pkg::PERIOD_MAX_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  trig_in,
  input  wire logic [3:0]  seq_trig,
  input  wire logic [31:0] parallel_digital_line
);

  if (NUM_UNITS != 2 && NUM_UNITS != 4) begin : g_bad_units
    $error("NUM_UNITS must be 2 or 4");
  end
  if (CNT_W < 8 || CNT_W > 32) begin : g_bad_cnt
    $error("CNT_W must lie in 8..32");
  end
  if (PER_W > 31 || (64'(1) << PER_W) <= 64'(PERIOD_MAX_CYC)) begin : g_bad_per
    $error("PER_W too narrow for PERIOD_MAX_CYC");
  end

  localparam logic [PER_W-1:0] PMIN = PER_W'(pmc_pkg::PERIOD_MIN_CYC);
  localparam logic [PER_W-1:0] PMAX = PER_W'(PERIOD_MAX_CYC);

  pmc_reg_if rif ();

  logic [pmc_pkg::NUM_IN-1:0] sync1_q;
  logic [pmc_pkg::NUM_IN-1:0] sync2_q;
  logic [31:0]                ts_q;

  logic [31:0]      ctrl_q   [NUM_UNITS];
  logic [PER_W-1:0] period_q [NUM_UNITS];
  logic [CNT_W-1:0] raw_q    [NUM_UNITS];
  logic [CNT_W-1:0] value_q  [NUM_UNITS];
  logic [31:0]      stamp_q  [NUM_UNITS];
  logic             new_q    [NUM_UNITS];
  logic             clr_q    [NUM_UNITS];

  logic             res_v [NUM_UNITS];
  logic [CNT_W-1:0] res_c [NUM_UNITS];
  logic [31:0]      res_s [NUM_UNITS];

  // Source index 0..3 are the trigger inputs, 4..35 the parallel lines
  function automatic logic pick_src(input logic [pmc_pkg::NUM_IN-1:0] v,
                                    input logic [5:0] sel);
    if (int'(sel) < pmc_pkg::NUM_SRC) begin
      pick_src = v[sel];
    end else begin
      pick_src = 1'b0;
    end
  endfunction : pick_src

  // Gate index 0..3 are the trigger inputs, 4..7 the sequencer triggers
  function automatic logic pick_gate(input logic [pmc_pkg::NUM_IN-1:0] v,
                                     input logic [2:0] sel);
    if (sel[2]) begin
      pick_gate = v[pmc_pkg::GATE_BASE + int'(sel[1:0])];
    end else begin
      pick_gate = v[sel[1:0]];
    end
  endfunction : pick_gate

  // Out-of-range periods are pulled to the nearest legal value
  function automatic logic [PER_W-1:0] clamp_per(input logic [31:0] w);
    if (w < 32'(PMIN)) begin
      clamp_per = PMIN;
    end else if (w > 32'(PMAX)) begin
      clamp_per = PMAX;
    end else begin
      clamp_per = w[PER_W-1:0];
    end
  endfunction : clamp_per

  function automatic logic [CNT_W-1:0] combine(input logic [1:0] op,
                                               input logic [CNT_W-1:0] own,
                                               input logic [CNT_W-1:0] other);
    case (op)
      pmc_pkg::OP_ADD: combine = own + other;
      pmc_pkg::OP_SUB: combine = own - other;
      default:         combine = own;
    endcase
  endfunction : combine

  pmc_apb_slave #(
    .NUM_UNITS (NUM_UNITS)
  ) u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rif     (rif)
  );

  // Two flops per input; only the second stage is ever looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {seq_trig, parallel_digital_line, trig_in}; // R21
      sync2_q <= sync1_q; // R21
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_q <= 32'h00000000;
    end else begin
      ts_q <= ts_q + 32'h00000001; // R19
    end
  end

  for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
    pmc_pkg::pmc_state_e state_q;
    logic             src_now;
    logic             gate_now;
    logic             src_q;
    logic             gate_q;
    logic             ev;
    logic             tmr_end;
    logic [1:0]       mode;
    logic [CNT_W-1:0] cnt_ev;
    logic [CNT_W-1:0] cnt_q;
    logic [PER_W-1:0] tmr_q;
    logic             rv_q;
    logic [CNT_W-1:0] rc_q;
    logic [31:0]      rs_q;

    assign mode     = ctrl_q[i][pmc_pkg::F_MODE +: 2];
    assign src_now  = pick_src(sync2_q, ctrl_q[i][pmc_pkg::F_SRC +: 6]); // R10
    assign gate_now = pick_gate(sync2_q, ctrl_q[i][pmc_pkg::F_GATE +: 3]); // R13
    // One event per clock: pulse rate is bounded by the data clock
    assign ev = (src_now & ~src_q & ctrl_q[i][pmc_pkg::F_RISE]) // R11 R20
              | (~src_now & src_q & ctrl_q[i][pmc_pkg::F_FALL]); // R12
    assign cnt_ev  = cnt_q + CNT_W'(ev);
    assign tmr_end = (tmr_q == period_q[i] - PER_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        src_q  <= 1'b0;
        gate_q <= 1'b0;
      end else begin
        src_q  <= src_now;
        gate_q <= gate_now;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state_q <= pmc_pkg::ST_IDLE;
        cnt_q   <= '0;
        tmr_q   <= '0;
        rv_q    <= 1'b0;
        rc_q    <= '0;
        rs_q    <= 32'h00000000;
      end else if (!ctrl_q[i][pmc_pkg::F_EN] || clr_q[i]) begin
        state_q <= pmc_pkg::ST_IDLE; // R17
        cnt_q   <= '0;
        tmr_q   <= '0;
        rv_q    <= 1'b0;
      end else begin
        rv_q <= 1'b0;
        case (state_q)
          pmc_pkg::ST_IDLE: begin
            cnt_q <= '0;
            tmr_q <= '0;
            if (mode == pmc_pkg::MODE_FREE) begin
              state_q <= pmc_pkg::ST_RUN;
            end else if (mode == pmc_pkg::MODE_GFREE && gate_now) begin
              state_q <= pmc_pkg::ST_RUN; // R2
            end else if (mode == pmc_pkg::MODE_GATED && gate_now && !gate_q) begin
              state_q <= pmc_pkg::ST_RUN; // R4
              cnt_q   <= CNT_W'(ev);
            end else if (mode == pmc_pkg::MODE_TAG && ev) begin
              state_q <= pmc_pkg::ST_HOLD; // R6
              rv_q    <= 1'b1;
              rc_q    <= CNT_W'(1);
              rs_q    <= ts_q;
            end
          end
          pmc_pkg::ST_RUN: begin
            if (mode == pmc_pkg::MODE_GATED) begin
              if (!gate_now) begin
                state_q <= pmc_pkg::ST_IDLE; // R4
                rv_q    <= 1'b1; // R5
                rc_q    <= cnt_q;
                rs_q    <= ts_q;
              end else begin
                cnt_q <= cnt_ev; // R4
              end
            end else if (mode == pmc_pkg::MODE_GFREE && !gate_now) begin
              state_q <= pmc_pkg::ST_IDLE; // R2
              cnt_q   <= '0;
              tmr_q   <= '0;
            end else if (mode == pmc_pkg::MODE_TAG) begin
              state_q <= pmc_pkg::ST_IDLE;
            end else if (tmr_end) begin
              // Only a completed period reports, so a short gate gives nothing
              rv_q  <= 1'b1; // R1 R3
              rc_q  <= cnt_ev;
              rs_q  <= ts_q;
              cnt_q <= '0; // R1
              tmr_q <= '0;
            end else begin
              cnt_q <= cnt_ev;
              tmr_q <= tmr_q + PER_W'(1);
            end
          end
          pmc_pkg::ST_HOLD: begin
            if (mode != pmc_pkg::MODE_TAG) begin
              state_q <= pmc_pkg::ST_IDLE;
            end else if (tmr_end) begin
              tmr_q <= '0; // R7
              cnt_q <= '0;
              if (cnt_ev != '0) begin
                rv_q <= 1'b1; // R8
                rc_q <= cnt_ev;
                rs_q <= ts_q;
              end else begin
                state_q <= pmc_pkg::ST_IDLE;
              end
            end else begin
              cnt_q <= cnt_ev; // R8
              tmr_q <= tmr_q + PER_W'(1); // R7
            end
          end
          default: begin
            state_q <= pmc_pkg::ST_IDLE;
          end
        endcase
      end
    end

    assign res_v[i] = rv_q;
    assign res_c[i] = rc_q;
    assign res_s[i] = rs_q;
  end

  // Register writes; a control write restarts the unit and its integrator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        ctrl_q[i]   <= pmc_pkg::CTRL_RST;
        period_q[i] <= PMIN;
        clr_q[i]    <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        clr_q[i] <= 1'b0;
        if (rif.wr && int'(rif.unit) == i && rif.regsel == pmc_pkg::REG_CTRL) begin
          ctrl_q[i] <= rif.wdata & pmc_pkg::CTRL_WMASK;
          clr_q[i]  <= 1'b1;
        end
        if (rif.wr && int'(rif.unit) == i && rif.regsel == pmc_pkg::REG_PERIOD) begin
          period_q[i] <= clamp_per(rif.wdata); // R9
        end
      end
    end
  end

  // Results: partner arithmetic, integration and the new-result flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        raw_q[i]   <= '0;
        value_q[i] <= '0;
        stamp_q[i] <= 32'h00000000;
        new_q[i]   <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        logic [CNT_W-1:0] other;
        logic [CNT_W-1:0] comb;
        other = res_v[i ^ 1] ? res_c[i ^ 1] : raw_q[i ^ 1]; // R15
        comb  = combine(ctrl_q[i][pmc_pkg::F_OP +: 2], res_c[i], other); // R14
        if (clr_q[i]) begin
          value_q[i] <= '0;
          new_q[i]   <= 1'b0;
        end else if (res_v[i]) begin
          raw_q[i]   <= res_c[i];
          value_q[i] <= ctrl_q[i][pmc_pkg::F_INTEG] ? value_q[i] + comb : comb; // R16
          stamp_q[i] <= res_s[i]; // R19
          new_q[i]   <= 1'b1; // R18
        end else if (rif.rd && int'(rif.unit) == i && rif.regsel == pmc_pkg::REG_VALUE) begin
          new_q[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    rif.rdata = 32'h00000000;
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (int'(rif.unit) == i) begin
        if (rif.regsel == pmc_pkg::REG_CTRL) begin
          rif.rdata = ctrl_q[i];
          rif.rdata[pmc_pkg::F_NEW] = new_q[i];
        end else if (rif.regsel == pmc_pkg::REG_PERIOD) begin
          rif.rdata = 32'(period_q[i]);
        end else if (rif.regsel == pmc_pkg::REG_VALUE) begin
          rif.rdata = 32'(value_q[i]); // R18
        end else begin
          rif.rdata = stamp_q[i];
        end
      end
    end
  end

endmodule : pmc_top
`default_nettype wire

// ==== sim/pmc_src_model.sv ====
/*
  Pulse and gate source model for the counter's trigger, sequencer and
  parallel lines. Assumes the bench calls its tasks just after a pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_src_model (
  input  wire logic   pclk,
  output logic [3:0]  trig_in,
  output logic [3:0]  seq_trig,
  output logic [31:0] parallel_digital_line
);
  // One flat pin vector: index equals the source code, sequencer gates above 35
  logic [39:0] lv_q = 40'h0;

  assign trig_in               = lv_q[3:0];
  assign parallel_digital_line = lv_q[35:4];
  assign seq_trig              = lv_q[39:36];

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc

  // Bitwise updates so concurrent callers never overwrite each other
  task automatic drive(input logic [39:0] m, input logic v);
    @(posedge pclk);
    foreach (m[i]) if (m[i]) lv_q[i] <= v;
  endtask : drive

  // Levels held at least two cycles so no edge is lost in the synchroniser
  task automatic pulses(input logic [39:0] m, input int n, input int hi, input int lo);
    repeat (n) begin
      drive(m, 1'b1);
      wait_cyc(hi - 1);
      drive(m, 1'b0);
      wait_cyc(lo - 1);
    end
  endtask : pulses
endmodule : pmc_src_model
`default_nettype wire

// ==== sim/pmc_top_checker.sv ====
/*
  Checker on the register bus ports of the pulse counter.
  Assumes it is bound into pmc_top and sees the same clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_top_checker #(
  parameter int PERIOD_MAX_CYC = pmc_pkg::PERIOD_MAX_CYC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_first;
    psel && penable && !pready;
  endsequence
  sequence s_rd;
    pready && !pwrite && !pslverr;
  endsequence

  a_ready_wait: assert property (s_setup ##1 s_first |=> pready)
    else $error("no answer one cycle into access");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held over two cycles");
  a_ready_idle: assert property (!(psel && penable) |=> !pready)
    else $error("ready without access");
  a_err_align: assert property (s_first ##0 paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_err_range: assert property (s_first ##0 paddr[11:6] != 6'h0 |=> pslverr)
    else $error("out of range access not refused");
  a_ok_map: assert property (s_first ##0 paddr[11:6] == 6'h0 ##0 paddr[1:0] == 2'h0
                             |=> !pslverr)
    else $error("mapped access refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_period_clamp: assert property (s_rd ##0 paddr[3:2] == 2'h1
                                   |-> prdata >= 32'h1 && prdata <= PERIOD_MAX_CYC)
    else $error("period out of range");
  a_ctrl_rsvd: assert property (s_rd ##0 paddr[3:2] == 2'h0 |-> prdata[30:17] == 14'h0)
    else $error("reserved control bits set");
endmodule : pmc_top_checker

bind pmc_top pmc_top_checker #(.PERIOD_MAX_CYC(PERIOD_MAX_CYC)) chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

// ==== sim/testbench.sv ====
/*
  Self-checking bench for the pulse counter: APB master tasks, expected
  counts kept in a queue, one scenario per counting mode.
  Assumes pmc_src_model drives all trigger, sequencer and parallel pins.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("ERROR %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module testbench;
  localparam int PMAX = 64;
  logic        pclk = 1'b0;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  trig_in;
  logic [3:0]  seq_trig;
  logic [31:0] parallel_digital_line;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  int          exp_q[$];

  always #50 pclk = ~pclk;
  always @(posedge pclk) if (presetn) cyc <= cyc + 1;

  // Short period bound keeps the clamp reachable in simulation
  pmc_top #(.PERIOD_MAX_CYC(PMAX)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .seq_trig(seq_trig),
    .parallel_digital_line(parallel_digital_line)
  );
  pmc_src_model src (
    .pclk(pclk), .trig_in(trig_in), .seq_trig(seq_trig),
    .parallel_digital_line(parallel_digital_line)
  );

  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input int u, input int r, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, 12'(u * 16 + r * 4), d, q, e);
  endtask : wr

  task automatic rd(input int u, input int r, output logic [31:0] q);
    logic e;
    apb(1'b0, 12'(u * 16 + r * 4), 32'h0, q, e);
  endtask : rd

  function automatic logic [31:0] cfg(int md, int ed, int sc, int gt, int op, int ig);
    return 32'(1 + md * 2 + ed * 8 + sc * 32 + gt * 2048 + op * 16384 + ig * 65536);
  endfunction : cfg

  // Gate window: n pulses on both sources, then m on the second only
  task automatic win(input int gb, input int sa, input int n, input int sb, input int m);
    src.drive(40'h1 << gb, 1'b1);
    src.wait_cyc(5);
    src.pulses(40'h1 << sa | 40'h1 << sb, n, 3, 3);
    src.pulses(40'h1 << sb, m, 3, 3);
    src.wait_cyc(5);
    src.drive(40'h1 << gb, 1'b0);
    src.wait_cyc(8);
  endtask : win

  initial begin
    repeat (10000) @(posedge pclk);
    n_mismatch++;
    results();
  end

  initial begin
    logic [31:0] v;
    logic [31:0] s1;
    logic        e;
    int          n;
    int          m;
    int          sc;
    int          gt;
    int          ed;
    int          tot;
    void'($urandom(32'hECA0));
    tot = 0;
    presetn <= 1'b0;
    paddr <= 12'h000;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h00000000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int u = 0; u < 4; u++) begin
      rd(u, 0, v);
      `CHK(v, pmc_pkg::CTRL_RST)
      rd(u, 1, v);
      `CHK(v, 1)
      rd(u, 2, v);
      `CHK(v, 0)
    end
    apb(1'b0, 12'h040, 32'h0, v, e);
    `CHK(e, 1'b1)
    apb(1'b1, 12'h006, 32'h5, v, e);
    `CHK(e, 1'b1)
    wr(0, 2, 32'hFFFF);
    rd(0, 2, v);
    `CHK(v, 0)
    wr(0, 1, 0);
    rd(0, 1, v);
    `CHK(v, 1)
    wr(0, 1, 32'hFFFFFF);
    rd(0, 1, v);
    `CHK(v, PMAX)
    n = 1 + $urandom % PMAX;
    wr(0, 1, n);
    rd(0, 1, v);
    `CHK(v, n)
    // Gated mode over every source pin and every gate pin, random edge choice
    for (int k = 0; k < pmc_pkg::NUM_SRC; k++) begin
      n = 1 + $urandom % 5;
      sc = k;
      gt = (k + 1) % 8;
      ed = 1 + $urandom % 3;
      wr(0, 0, cfg(2, ed, sc, gt, 0, 0));
      src.pulses(40'h1 << sc, 2, 3, 3);
      win(gt < 4 ? gt : gt + 32, sc, n, sc, 0);
      exp_q.push_back(ed == 3 ? 2 * n : n);
      rd(0, 2, v);
      `CHK(v, exp_q.pop_front())
    end
    wr(0, 0, cfg(2, 1, 4, 3, 1, 0));
    wr(1, 0, cfg(2, 1, 5, 3, 2, 0));
    wr(2, 0, cfg(2, 1, 4, 3, 0, 1));
    wr(3, 0, cfg(2, 1, 5, 3, 0, 0) & ~32'h1);
    for (int k = 0; k < 2; k++) begin
      n = 1 + $urandom % 4;
      m = 1 + $urandom % 4;
      tot += n;
      win(3, 4, n, 5, m);
      rd(0, 2, v);
      `CHK(v, 2 * n + m)
      rd(1, 2, v);
      `CHK(v, m)
    end
    rd(2, 2, v);
    `CHK(v, tot)
    rd(3, 2, v);
    `CHK(v, 0)
    rd(3, 0, v);
    `CHK(v[31], 1'b0)
    // One pulse every four cycles gives exactly four per 16-cycle period
    wr(0, 1, 16);
    wr(1, 1, 16);
    wr(0, 0, cfg(0, 1, 4, 3, 0, 0));
    wr(1, 0, cfg(1, 1, 4, 3, 0, 0));
    fork
      src.pulses(40'h10, 50, 2, 2);
    join_none
    src.wait_cyc(40);
    rd(0, 2, v);
    `CHK(v, 4)
    rd(1, 2, v);
    `CHK(v, 0)
    src.pulses(40'h8, 1, 10, 2);
    src.wait_cyc(4);
    rd(1, 2, v);
    `CHK(v, 0)
    src.drive(40'h8, 1'b1);
    src.wait_cyc(40);
    rd(1, 2, v);
    `CHK(v, 4)
    src.drive(40'h8, 1'b0);
    wr(2, 1, 60);
    wr(2, 0, cfg(3, 1, 6, 3, 0, 0));
    src.pulses(40'h40, 1, 3, 3);
    rd(2, 2, v);
    `CHK(v, 1)
    rd(2, 3, s1);
    `CHK(cyc - s1 < 20, 1'b1)
    src.pulses(40'h40, 3, 3, 3);
    src.wait_cyc(60);
    rd(2, 2, v);
    `CHK(v, 3)
    rd(2, 3, v);
    `CHK(v - s1 >= 60, 1'b1)
    results();
  end
endmodule : testbench
`default_nettype wire
